/* File: rtl/sslc_stack_unit.sv */
`timescale 1ns/1ps
`include "sslc_consts.svh"

// How it works
// - Stack pointer holds the first free word; stack grows toward higher addresses.
// - Push uses pointer then increments; pop decrements first then uses it.
// - Call push clears the upper byte of the program counter word.
// - Exception push places status low byte beside the program counter upper byte.
// - Stack limit register gets no value from reset.
// - Bit 0 of limit and pointer always reads and acts as zero.
// - Every address made through the stack pointer is compared with the limit.
// - Push at pointer equal to limit succeeds; the next push traps.
// - Any stack address below 0800h raises an underflow trap.
module sslc_stack_unit
   import sslc_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Stack operation request from address generation.
   input wire sslc_op_t op_i,
   input wire sslc_push_kind_t push_kind_i,
   input wire logic [15:0] push_data_i,
   input wire logic [22:0] pc_i,
   input wire logic [7:0] status_low_byte_i,
   input wire logic [15:0] ea_offset_i,
   // Register writes from the core.
   input wire logic sp_wr_i,
   input wire logic [15:0] sp_wdata_i,
   input wire logic limit_wr_i,
   input wire logic [15:0] limit_wdata_i,
   // Address and data towards memory.
   output logic [15:0] effective_addr_o,
   output logic addr_valid_o,
   output logic [15:0] push_word_lo_o,
   output logic [15:0] push_word_hi_o,
   // Register views and trap request.
   output logic [15:0] stack_pointer_o,
   output logic [15:0] stack_limit_o,
   output logic stack_trap_o,
   output logic overflow_o,
   output logic underflow_o
);

   logic [15:0] stack_pointer_reg;
   logic [15:0] stack_limit_reg;
   logic [15:0] effective_addr;
   logic [15:0] next_sp;
   logic uses_sp;
   logic limit_seen;

   function automatic logic [15:0] sslc_align(input logic [15:0] v);
      sslc_align = v & `SSLC_ALIGN_MASK;
   endfunction : sslc_align

   // Only pushes and pops move the pointer; indirect accesses leave it where it is.
   function automatic logic sslc_moves_sp(input sslc_op_t op);
      sslc_moves_sp = (op == SSLC_OP_PUSH) || (op == SSLC_OP_POP);
   endfunction : sslc_moves_sp

   // Address generation: push uses the pointer as is, pop the decremented one.
   always_comb begin
      uses_sp = 1'b1;
      next_sp = stack_pointer_reg;
      effective_addr = stack_pointer_reg;
      case (op_i)
         SSLC_OP_PUSH: begin
            effective_addr = stack_pointer_reg;
            next_sp = 16'(stack_pointer_reg + `SSLC_WORD_STEP);
         end
         SSLC_OP_POP: begin
            next_sp = 16'(stack_pointer_reg - `SSLC_WORD_STEP);
            effective_addr = next_sp;
         end
         SSLC_OP_EA: begin
            effective_addr = sslc_align(16'(stack_pointer_reg + ea_offset_i));
         end
         default: begin
            uses_sp = 1'b0;
         end
      endcase
   end

   // The pointer moves upward on pushes and always names the next free word.
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         stack_pointer_reg <= `SSLC_SP_RESET;
      end else if (sp_wr_i) begin
         stack_pointer_reg <= sslc_align(sp_wdata_i);
      end else if (sslc_moves_sp(op_i)) begin
         stack_pointer_reg <= next_sp;
      end
   end

   // The limit is deliberately outside the reset so software must set it.
   always_ff @(posedge core_clk_i) begin
      if (limit_wr_i) begin
         stack_limit_reg <= sslc_align(limit_wdata_i);
      end
   end

   // Checking aid with no reset, so it stays unknown until the first limit write, just like the limit.
   // It lets the a_limit_kept check stay quiet while the limit has no value yet; the other limit checks do not use it.
   always_ff @(posedge core_clk_i) begin
      if (limit_wr_i) begin
         limit_seen <= 1'b1;
      end
   end

   // Push word formatting for call and exception frames.
   always_comb begin
      push_word_lo_o = push_data_i;
      push_word_hi_o = 16'h0000;
      case (push_kind_i)
         SSLC_PUSH_CALL: begin
            push_word_lo_o = {pc_i[15:1], 1'b0};
            push_word_hi_o = {8'h00, 1'b0, pc_i[22:16]};
         end
         SSLC_PUSH_EXC: begin
            push_word_lo_o = {pc_i[15:1], 1'b0};
            push_word_hi_o = {status_low_byte_i, 1'b0, pc_i[22:16]};
         end
         default: begin
            push_word_lo_o = push_data_i;
            push_word_hi_o = 16'h0000;
         end
      endcase
   end

   // Overflow is strictly above the limit so a push at the limit completes.
   // An unwritten limit is unknown; software owns writing it before stack use.
   always_comb begin
      overflow_o = uses_sp && (effective_addr > stack_limit_reg);
      underflow_o = uses_sp && (effective_addr < `SSLC_STACK_FLOOR);
      stack_trap_o = overflow_o || underflow_o;
   end

   assign effective_addr_o = effective_addr;
   assign addr_valid_o = uses_sp;
   assign stack_pointer_o = stack_pointer_reg;
   assign stack_limit_o = stack_limit_reg;

   sequence s_push_at_limit;
      op_i == SSLC_OP_PUSH && !sp_wr_i && !limit_wr_i && stack_pointer_reg == stack_limit_reg;
   endsequence

   sequence s_next_push;
      op_i == SSLC_OP_PUSH;
   endsequence

   a_push_post_inc: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (op_i == SSLC_OP_PUSH && !sp_wr_i) |-> effective_addr_o == stack_pointer_reg
         ##1 stack_pointer_reg == 16'($past(stack_pointer_reg) + `SSLC_WORD_STEP))
      else $error("push did not post-increment");
   a_pop_pre_dec: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (op_i == SSLC_OP_POP && !sp_wr_i) |=> stack_pointer_reg == $past(effective_addr_o))
      else $error("pop address is not the new pointer");
   a_limit_edge_ok: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_push_at_limit |-> !overflow_o)
      else $error("push at limit trapped");
   a_limit_next_trap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_push_at_limit ##1 (s_next_push [*1]) |-> stack_trap_o)
      else $error("push after limit did not trap");
   a_floor_trap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (addr_valid_o && effective_addr_o < `SSLC_STACK_FLOOR) |-> stack_trap_o && underflow_o)
      else $error("underflow not trapped");
   a_no_false_trap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      stack_trap_o |-> addr_valid_o)
      else $error("trap without stack address");
   a_sp_aligned: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      $past(sp_wr_i) |-> stack_pointer_reg[0] == 1'b0)
      else $error("pointer not word aligned");
   a_limit_aligned: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      $past(limit_wr_i) |-> stack_limit_o == ($past(limit_wdata_i) & `SSLC_ALIGN_MASK))
      else $error("limit write wrong");
   a_call_upper_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      push_kind_i == SSLC_PUSH_CALL |-> push_word_hi_o[15:8] == 8'h00)
      else $error("call push upper byte set");
   a_exc_status: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      push_kind_i == SSLC_PUSH_EXC |-> push_word_hi_o[15:8] == status_low_byte_i)
      else $error("exception push lacks status byte");
   a_pointer_grows: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (op_i == SSLC_OP_PUSH && !sp_wr_i && stack_pointer_reg < 16'hFFFE)
         |=> stack_pointer_reg > $past(stack_pointer_reg))
      else $error("stack did not grow upward");

   // Pointer register checks: reset value, software writes and holding still between moves.
   a_sp_reset_value: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !$past(rst_n_i) |-> stack_pointer_o == `SSLC_SP_RESET)
      else $error("pointer not at reset value");
   a_sp_write_lands: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ($past(rst_n_i) && $past(sp_wr_i)) |-> stack_pointer_o == ($past(sp_wdata_i) & `SSLC_ALIGN_MASK))
      else $error("pointer write did not land aligned");
   a_idle_sp_holds: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (!sslc_moves_sp(op_i) && !sp_wr_i) |=> $stable(stack_pointer_o))
      else $error("pointer moved without push or pop");

   // Address checks: every pointer-based access is formed and compared in its own cycle.
   a_pop_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (op_i == SSLC_OP_POP) |-> effective_addr_o == 16'(stack_pointer_o - `SSLC_WORD_STEP))
      else $error("pop address not one word below pointer");
   a_ea_address: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (op_i == SSLC_OP_EA) |-> effective_addr_o == (16'(stack_pointer_o + ea_offset_i) & `SSLC_ALIGN_MASK))
      else $error("indirect stack address wrong");
   a_ovf_flagged: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (addr_valid_o && effective_addr_o > stack_limit_o) |-> overflow_o && stack_trap_o)
      else $error("address above limit not trapped");
   a_ovf_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (addr_valid_o && effective_addr_o <= stack_limit_o) |-> !overflow_o)
      else $error("overflow raised at or below limit");

   // Frame word checks for the two program counter pushes.
   a_call_frame_lo: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      push_kind_i == SSLC_PUSH_CALL |-> push_word_lo_o == {pc_i[15:1], 1'b0} && push_word_hi_o[6:0] == pc_i[22:16])
      else $error("call frame program counter wrong");
   a_exc_frame_pc: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      push_kind_i == SSLC_PUSH_EXC |-> push_word_hi_o[6:0] == pc_i[22:16] && push_word_lo_o == {pc_i[15:1], 1'b0})
      else $error("exception frame program counter wrong");

   // No disable here on purpose: the limit must come through a reset untouched.
   a_limit_kept: assert property (@(posedge core_clk_i)
      (limit_seen && !limit_wr_i) |=> $stable(stack_limit_o))
      else $error("limit changed without a write");

endmodule : sslc_stack_unit

/* File: rtl/sslc_consts.svh */
`ifndef SSLC_CONSTS_SVH
`define SSLC_CONSTS_SVH

// Lowest legal stack address; below this lies the special function register space.
`define SSLC_STACK_FLOOR 16'h0800
// One stack word in byte addresses.
`define SSLC_WORD_STEP 16'h0002
// Word-alignment mask that clears bit 0.
`define SSLC_ALIGN_MASK 16'hFFFE
// Stack pointer value after reset.
`define SSLC_SP_RESET 16'h0800

`endif

/* File: rtl/sslc_pkg.sv */
package sslc_pkg;
   typedef enum logic [1:0] {
      SSLC_OP_NONE = 2'h0,
      SSLC_OP_PUSH = 2'h1,
      SSLC_OP_POP = 2'h3,
      SSLC_OP_EA = 2'h2
   } sslc_op_t;

   typedef enum logic [1:0] {
      SSLC_PUSH_DATA = 2'h0,
      SSLC_PUSH_CALL = 2'h1,
      SSLC_PUSH_EXC = 2'h3
   } sslc_push_kind_t;
endpackage : sslc_pkg

/* File: tb/sslc_trap_model.sv */
`timescale 1ns/1ps
module sslc_trap_model (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Trap request from the stack unit.
   input wire logic stack_trap_i,
   output logic [7:0] trap_count_o
);
   // The trap logic takes a request on the edge that ends the offending cycle.
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         trap_count_o <= 8'h00;
      end else if (stack_trap_i) begin
         trap_count_o <= trap_count_o + 8'h01;
      end
   end
endmodule : sslc_trap_model

/* File: tb/software_stack_limit_check_tb_top.sv */
`timescale 1ns/1ps
module software_stack_limit_check_tb_top
   import sslc_pkg::*;
;
   typedef struct {sslc_op_t op; sslc_push_kind_t k; logic [15:0] d, ea, a; logic [1:0] f; logic [15:0] lo, hi;} sslc_row_t;
   sslc_row_t rows [10] = '{
      '{SSLC_OP_PUSH, SSLC_PUSH_DATA, 16'hA55A, 16'h0000, 16'h0800, 2'h0, 16'hA55A, 16'h0000},
      '{SSLC_OP_POP, SSLC_PUSH_DATA, 16'h0000, 16'h0000, 16'h0800, 2'h0, 16'h0000, 16'h0000},
      '{SSLC_OP_POP, SSLC_PUSH_DATA, 16'h0000, 16'h0000, 16'h07FE, 2'h1, 16'h0000, 16'h0000},
      '{SSLC_OP_PUSH, SSLC_PUSH_DATA, 16'h0000, 16'h0000, 16'h07FE, 2'h1, 16'h0000, 16'h0000},
      '{SSLC_OP_PUSH, SSLC_PUSH_CALL, 16'h0000, 16'h0000, 16'h0800, 2'h0, 16'h1234, 16'h005A},
      '{SSLC_OP_PUSH, SSLC_PUSH_EXC, 16'h0000, 16'h0000, 16'h0802, 2'h0, 16'h1234, 16'hC35A},
      '{SSLC_OP_PUSH, SSLC_PUSH_DATA, 16'h0001, 16'h0000, 16'h0804, 2'h0, 16'h0001, 16'h0000},
      '{SSLC_OP_PUSH, SSLC_PUSH_DATA, 16'h0000, 16'h0000, 16'h0806, 2'h2, 16'h0000, 16'h0000},
      '{SSLC_OP_EA, SSLC_PUSH_DATA, 16'h0000, 16'hFFFB, 16'h0802, 2'h0, 16'h0000, 16'h0000},
      '{SSLC_OP_EA, SSLC_PUSH_DATA, 16'h0000, 16'hFFF0, 16'h07F8, 2'h1, 16'h0000, 16'h0000}};
   logic clk = 1'b0, rst_n, sp_wr, lim_wr, av, trap, ov, un;
   sslc_op_t op;
   sslc_push_kind_t kind;
   logic [15:0] pdata, ea, sp_wd, lim_wd, addr, lo, hi, sp, lim;
   logic [22:0] pc;
   logic [7:0] stat, tcount;
   int errors = 0, checked = 0;
   always #10 clk = ~clk;
   sslc_stack_unit sslc_stack_unit_i (.core_clk_i(clk), .rst_n_i(rst_n), .op_i(op), .push_kind_i(kind),
      .push_data_i(pdata), .pc_i(pc), .status_low_byte_i(stat), .ea_offset_i(ea), .sp_wr_i(sp_wr),
      .sp_wdata_i(sp_wd), .limit_wr_i(lim_wr), .limit_wdata_i(lim_wd), .effective_addr_o(addr),
      .addr_valid_o(av), .push_word_lo_o(lo), .push_word_hi_o(hi), .stack_pointer_o(sp),
      .stack_limit_o(lim), .stack_trap_o(trap), .overflow_o(ov), .underflow_o(un));
   sslc_trap_model sslc_trap_model_i (.core_clk_i(clk), .rst_n_i(rst_n), .stack_trap_i(trap), .trap_count_o(tcount));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic test_done();
      $display("Checks %0d, errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done
   initial begin
      rst_n = 1'b0; op = SSLC_OP_NONE; kind = SSLC_PUSH_DATA; pdata = 16'h0000; pc = 23'h5A1235;
      stat = 8'hC3; ea = 16'h0000; sp_wr = 1'b0; sp_wd = 16'h0000; lim_wr = 1'b0; lim_wd = 16'h0805;
      repeat (2) tick();
      rst_n = 1'b1;
      chk(sp, 16'h0800);
      lim_wr = 1'b1;
      tick();
      lim_wr = 1'b0;
      chk(lim, 16'h0804);
      // The first access after the limit write is a push, not an indirect read.
      foreach (rows[i]) begin
         op = rows[i].op; kind = rows[i].k; pdata = rows[i].d; ea = rows[i].ea;
         #5;
         chk(addr, rows[i].a);
         chk({14'h0000, ov, un}, {14'h0000, rows[i].f});
         chk({15'h0000, trap}, {15'h0000, |rows[i].f});
         chk({15'h0000, av}, {15'h0000, rows[i].op != SSLC_OP_NONE});
         chk(lo, rows[i].lo);
         chk(hi, rows[i].hi);
         tick();
      end
      chk(sp, 16'h0808);
      chk({8'h00, tcount}, 16'h0004);
      // With no access requested the pointer may sit above the limit without a trap.
      op = SSLC_OP_NONE;
      tick();
      chk({14'h0000, av, trap}, 16'h0000);
      op = SSLC_OP_PUSH; sp_wr = 1'b1; sp_wd = 16'h0901;
      tick();
      op = SSLC_OP_NONE; sp_wr = 1'b0;
      chk(sp, 16'h0900);
      tick();
      chk(sp, 16'h0900);
      rst_n = 1'b0;
      tick();
      rst_n = 1'b1;
      chk(sp, 16'h0800);
      chk(lim, 16'h0804);
      test_done();
   end
   initial begin
      #20000;
      errors++;
      test_done();
   end
endmodule : software_stack_limit_check_tb_top
